//--- tcu8_pkg.sv
// Purpose: Constants and state layout of the 8-bit timer counter/compare unit
// Assumes: One clock domain, byte-wide register port
// Notes:   Offsets are word indices on the plain register port
package tcu8_pkg;

    // Register offsets
    localparam logic [7:0] ADDR_CTRL  = 8'h00;
    localparam logic [7:0] ADDR_COUNT = 8'h01;
    localparam logic [7:0] ADDR_CMP   = 8'h02;
    localparam logic [7:0] ADDR_FLAGS = 8'h03;
    localparam logic [7:0] ADDR_IEN   = 8'h04;

    // Control register fields
    localparam int CTRL_WGM_LSB   = 0;
    localparam int CTRL_COM_LSB   = 2;
    localparam int CTRL_CS_LSB    = 4;
    localparam int CTRL_FORCE_BIT = 7;

    // Flag and enable bit positions
    localparam int FLAG_CMP_BIT = 0;
    localparam int FLAG_OVF_BIT = 1;

    // Counter extremes and count step
    localparam logic [7:0] CNT_BOTTOM = 8'h00;
    localparam logic [7:0] CNT_MAX    = 8'hff;
    localparam logic [7:0] CNT_ONE    = 8'h01;

    // Waveform modes
    localparam logic [1:0] WGM_NORMAL = 2'h0;
    localparam logic [1:0] WGM_PHASE  = 2'h1;
    localparam logic [1:0] WGM_CTC    = 2'h2;
    localparam logic [1:0] WGM_FAST   = 2'h3;

    // Output actions
    localparam logic [1:0] COM_NONE   = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_CLEAR  = 2'h2;
    localparam logic [1:0] COM_SET    = 2'h3;

    localparam logic [2:0] CS_STOPPED = 3'h0;

    typedef struct packed {
        logic [7:0] counter_value;
        logic       count_down;
        logic [7:0] compare_value;
        logic [7:0] compare_buf;
        logic [1:0] waveform_mode;
        logic [1:0] output_action;
        logic [2:0] clock_select;
        logic       compare_flag;
        logic       overflow_flag;
        logic       compare_irq_enable;
        logic       overflow_irq_enable;
        logic       compare_output_bit;
        logic       block;
        logic [7:0] rdata;
    } tcu8_state_type;

    localparam tcu8_state_type STATE_RESET = '0;

endpackage

//--- tcu8_top.sv
// Purpose: Counter unit and output compare unit of an 8-bit timer
// Assumes: TICK_EN is a one-cycle enable from an outside prescaler
// Notes:   Registers on a plain port, read data one cycle after the strobe
//
// Overview of operation
// - Clock select zero gives no tick; counter stays stopped.
// - Each tick clears, increments or decrements the counter per mode.
// - Counter readable and writable always; a write beats clear and count.
// - Waveform mode bits pick the count sequence and overflow flag timing.
// - Top shows counter at its top value, bottom shows counter at zero.
// - Counter equal to compare value sets compare flag at next tick.
// - Flag with enable and global enable requests interrupt; service clears.
// - Writing one to the flag bit clears it; zero leaves it.
// - PWM modes buffer compare value, loaded at the maximum while counting up only.
// - Buffered mode accesses hit the buffer, else the active compare value.
// - Force strobe in non-PWM modes acts like a match, no flag, no clear.
// - Counter write suppresses matches in the next tick, even when stopped.
// - Output bit survives mode changes and resets to zero.
// - Output action changes are unbuffered; next match uses them.
// - Nonzero output action routes the output bit to the pin.
// - Pin shows a value only while its direction selects output.
// - Output action zero leaves the output bit untouched on a match.
// - Zero is bottom and 255 is maximum.
// - Top is maximum or compare value depending on mode.
//
// Added by the designer: the register addresses and the address-and-strobe port.
module tcu8_top
(
    // Clock and reset
    input  wire logic       REF_CLK,
    input  wire logic       SYS_RST,
    // Register port
    input  wire logic [7:0] REG_ADDR,
    input  wire logic [7:0] REG_WDATA,
    input  wire logic       REG_WR,
    input  wire logic       REG_RD,
    output logic      [7:0] REG_RDATA,
    // Timer tick and processor interrupt control
    input  wire logic       TICK_EN,
    input  wire logic       GLOBAL_IE,
    input  wire logic       ACK_CMP,
    input  wire logic       ACK_OVF,
    output logic            IRQ_CMP,
    output logic            IRQ_OVF,
    // Counter extremes for the waveform generator
    output logic            CNT_TOP,
    output logic            CNT_BOT,
    // Output pin
    input  wire logic       PORT_OUT,
    input  wire logic       OUTPUT_PIN_DIRECTION,
    output logic            OC_PIN_O,
    output logic            OC_PIN_OE
);

    tcu8_pkg::tcu8_state_type st_q;
    tcu8_pkg::tcu8_state_type st_d;

    logic       tick;
    logic       pwm;
    logic       match;
    logic       hit;
    logic       wr_ctrl;
    logic       wr_cnt;
    logic       wr_cmp;
    logic       wr_flags;
    logic       wr_ien;
    logic       force_cmp;
    logic       cmp_set;
    logic       ovf_set;
    logic       load_buf;
    logic [7:0] top_val;

    assign tick      = TICK_EN
                       && (st_q.clock_select != tcu8_pkg::CS_STOPPED);
    assign pwm       = st_q.waveform_mode[0];
    assign match     = (st_q.counter_value == st_q.compare_value);
    assign hit       = tick && match && !st_q.block;
    assign wr_ctrl   = REG_WR && (REG_ADDR == tcu8_pkg::ADDR_CTRL);
    assign wr_cnt    = REG_WR && (REG_ADDR == tcu8_pkg::ADDR_COUNT);
    assign wr_cmp    = REG_WR && (REG_ADDR == tcu8_pkg::ADDR_CMP);
    assign wr_flags  = REG_WR && (REG_ADDR == tcu8_pkg::ADDR_FLAGS);
    assign wr_ien    = REG_WR && (REG_ADDR == tcu8_pkg::ADDR_IEN);
    assign force_cmp = wr_ctrl && REG_WDATA[tcu8_pkg::CTRL_FORCE_BIT]
                       && !REG_WDATA[tcu8_pkg::CTRL_WGM_LSB];
    assign cmp_set   = hit;
    assign ovf_set   = tick && (((st_q.waveform_mode != tcu8_pkg::WGM_PHASE)
                       && (st_q.counter_value == tcu8_pkg::CNT_MAX))
                       || ((st_q.waveform_mode == tcu8_pkg::WGM_PHASE)
                       && st_q.count_down
                       && (st_q.counter_value == tcu8_pkg::CNT_BOTTOM)));
    assign load_buf  = tick && pwm && !st_q.count_down
                       && (st_q.counter_value == tcu8_pkg::CNT_MAX);
    assign top_val   = (st_q.waveform_mode == tcu8_pkg::WGM_CTC)
                       ? st_q.compare_value : tcu8_pkg::CNT_MAX;

    always_comb
    begin
        st_d = st_q;
        // Counting sequence per mode
        if (tick)
        begin
            st_d.block = 1'b0;
            unique case (st_q.waveform_mode)
                tcu8_pkg::WGM_NORMAL,
                tcu8_pkg::WGM_FAST:
                begin
                    st_d.counter_value = st_q.counter_value + tcu8_pkg::CNT_ONE;
                end
                tcu8_pkg::WGM_CTC:
                begin
                    if (hit)
                    begin
                        st_d.counter_value = tcu8_pkg::CNT_BOTTOM;
                    end
                    else
                    begin
                        st_d.counter_value = st_q.counter_value
                                             + tcu8_pkg::CNT_ONE;
                    end
                end
                tcu8_pkg::WGM_PHASE:
                begin
                    if (!st_q.count_down)
                    begin
                        if (st_q.counter_value == tcu8_pkg::CNT_MAX)
                        begin
                            st_d.count_down    = 1'b1;
                            st_d.counter_value = st_q.counter_value
                                                 - tcu8_pkg::CNT_ONE;
                        end
                        else
                        begin
                            st_d.counter_value = st_q.counter_value
                                                 + tcu8_pkg::CNT_ONE;
                        end
                    end
                    else if (st_q.counter_value == tcu8_pkg::CNT_BOTTOM)
                    begin
                        st_d.count_down    = 1'b0;
                        st_d.counter_value = tcu8_pkg::CNT_ONE;
                    end
                    else
                    begin
                        st_d.counter_value = st_q.counter_value
                                             - tcu8_pkg::CNT_ONE;
                    end
                end
            endcase
            if (st_q.waveform_mode != tcu8_pkg::WGM_PHASE)
            begin
                st_d.count_down = 1'b0;
            end
        end
        if (load_buf)
        begin
            st_d.compare_value = st_q.compare_buf;
        end

        // Output bit on a match; action zero does nothing
        if (hit && (st_q.output_action != tcu8_pkg::COM_NONE))
        begin
            if (!pwm)
            begin
                unique case (st_q.output_action)
                    tcu8_pkg::COM_TOGGLE:
                        st_d.compare_output_bit = !st_q.compare_output_bit;
                    tcu8_pkg::COM_CLEAR:
                        st_d.compare_output_bit = 1'b0;
                    default:
                        st_d.compare_output_bit = 1'b1;
                endcase
            end
            else if (st_q.output_action[1])
            begin
                // Clear-type action clears on the upward match
                st_d.compare_output_bit = st_q.output_action[0]
                                          ^ st_q.count_down;
            end
        end
        // Fast PWM restores the level at bottom
        if (tick && (st_q.waveform_mode == tcu8_pkg::WGM_FAST)
            && (st_q.counter_value == tcu8_pkg::CNT_MAX)
            && st_q.output_action[1])
        begin
            st_d.compare_output_bit = !st_q.output_action[0];
        end

        // Flags: clear first so that a same-cycle set wins
        if (wr_flags && REG_WDATA[tcu8_pkg::FLAG_CMP_BIT])
        begin
            st_d.compare_flag = 1'b0;
        end
        if (wr_flags && REG_WDATA[tcu8_pkg::FLAG_OVF_BIT])
        begin
            st_d.overflow_flag = 1'b0;
        end
        if (ACK_CMP)
        begin
            st_d.compare_flag = 1'b0;
        end
        if (ACK_OVF)
        begin
            st_d.overflow_flag = 1'b0;
        end
        if (cmp_set)
        begin
            st_d.compare_flag = 1'b1;
        end
        if (ovf_set)
        begin
            st_d.overflow_flag = 1'b1;
        end

        // Register writes
        if (wr_ctrl)
        begin
            st_d.waveform_mode = REG_WDATA[tcu8_pkg::CTRL_WGM_LSB +: 2];
            st_d.output_action = REG_WDATA[tcu8_pkg::CTRL_COM_LSB +: 2];
            st_d.clock_select  = REG_WDATA[tcu8_pkg::CTRL_CS_LSB +: 3];
        end
        if (force_cmp)
        begin
            unique case (REG_WDATA[tcu8_pkg::CTRL_COM_LSB +: 2])
                tcu8_pkg::COM_NONE:
                    st_d.compare_output_bit = st_q.compare_output_bit;
                tcu8_pkg::COM_TOGGLE:
                    st_d.compare_output_bit = !st_q.compare_output_bit;
                tcu8_pkg::COM_CLEAR:
                    st_d.compare_output_bit = 1'b0;
                tcu8_pkg::COM_SET:
                    st_d.compare_output_bit = 1'b1;
            endcase
        end
        if (wr_cnt)
        begin
            st_d.counter_value = REG_WDATA;
            st_d.block         = 1'b1;
        end
        if (wr_cmp)
        begin
            st_d.compare_buf = REG_WDATA;
            if (!pwm)
            begin
                st_d.compare_value = REG_WDATA;
            end
        end
        if (wr_ien)
        begin
            st_d.compare_irq_enable  = REG_WDATA[tcu8_pkg::FLAG_CMP_BIT];
            st_d.overflow_irq_enable = REG_WDATA[tcu8_pkg::FLAG_OVF_BIT];
        end

        // Read data for the next cycle
        st_d.rdata = 8'h00;
        if (REG_RD)
        begin
            unique case (REG_ADDR)
                tcu8_pkg::ADDR_CTRL:
                    st_d.rdata = {1'b0, st_q.clock_select,
                                  st_q.output_action, st_q.waveform_mode};
                tcu8_pkg::ADDR_COUNT:
                    st_d.rdata = st_q.counter_value;
                tcu8_pkg::ADDR_CMP:
                    st_d.rdata = pwm ? st_q.compare_buf
                                     : st_q.compare_value;
                tcu8_pkg::ADDR_FLAGS:
                    st_d.rdata = {6'h00, st_q.overflow_flag,
                                  st_q.compare_flag};
                tcu8_pkg::ADDR_IEN:
                    st_d.rdata = {6'h00, st_q.overflow_irq_enable,
                                  st_q.compare_irq_enable};
                default:
                    st_d.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge REF_CLK)
    begin
        if (SYS_RST)
        begin
            st_q <= tcu8_pkg::STATE_RESET;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign REG_RDATA = st_q.rdata;
    assign IRQ_CMP   = st_q.compare_flag && st_q.compare_irq_enable
                       && GLOBAL_IE;
    assign IRQ_OVF   = st_q.overflow_flag && st_q.overflow_irq_enable
                       && GLOBAL_IE;
    assign CNT_TOP   = (st_q.counter_value == top_val);
    assign CNT_BOT   = (st_q.counter_value == tcu8_pkg::CNT_BOTTOM);
    assign OC_PIN_O  = (st_q.output_action != tcu8_pkg::COM_NONE)
                       ? st_q.compare_output_bit : PORT_OUT;
    assign OC_PIN_OE = OUTPUT_PIN_DIRECTION;

    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (SYS_RST);

    AST_STOPPED: assert property (
        (st_q.clock_select == tcu8_pkg::CS_STOPPED) && !wr_cnt
        |=> $stable(st_q.counter_value))
        else $error("counter moved while stopped");
    AST_WR_PRIO: assert property (
        wr_cnt |=> (st_q.counter_value == $past(REG_WDATA)) && st_q.block)
        else $error("counter write lost");
    AST_CMP_SET: assert property (
        hit |=> st_q.compare_flag)
        else $error("match did not set compare flag");
    AST_BLOCK: assert property (
        st_q.block && tick && !wr_cnt
        |=> !$rose(st_q.compare_flag) && !st_q.block)
        else $error("match not blocked after counter write");
    AST_W1C: assert property (
        wr_flags && REG_WDATA[tcu8_pkg::FLAG_CMP_BIT] && !cmp_set
        |=> !st_q.compare_flag)
        else $error("compare flag not cleared by write");
    AST_ACK: assert property (
        ACK_CMP && !cmp_set |=> !st_q.compare_flag && !IRQ_CMP)
        else $error("service did not clear compare flag");
    AST_BYPASS: assert property (
        wr_cmp && !pwm && !wr_ctrl
        |=> st_q.compare_value == $past(REG_WDATA))
        else $error("direct compare write lost");
    AST_PWM_HOLD: assert property (
        pwm && !load_buf && !wr_ctrl |=> $stable(st_q.compare_value))
        else $error("active compare changed off top");
    AST_FORCE: assert property (
        force_cmp && !tick && !wr_flags
        |=> !$rose(st_q.compare_flag) && $stable(st_q.counter_value))
        else $error("force changed flag or counter");
    AST_COM0: assert property (
        (st_q.output_action == tcu8_pkg::COM_NONE) && !wr_ctrl
        |=> $stable(st_q.compare_output_bit))
        else $error("output bit moved with no action");
    AST_PIN: assert property (
        (st_q.output_action != tcu8_pkg::COM_NONE)
        |-> (OC_PIN_O == st_q.compare_output_bit)
            && (OC_PIN_OE == OUTPUT_PIN_DIRECTION))
        else $error("pin not driven from output bit");
    AST_RST: assert property (
        disable iff (1'b0) SYS_RST |=> !st_q.compare_output_bit)
        else $error("output bit not cleared by reset");

    COV_CTC_CLEAR: cover property (
        hit && (st_q.waveform_mode == tcu8_pkg::WGM_CTC));
    COV_PWM_LOAD: cover property (load_buf);
    COV_FORCE: cover property (force_cmp);

endmodule

//--- tcu8_tb.sv
// Purpose: Self-checking bench for the timer counter/compare unit
// Assumes: Register port with read data one cycle after the read strobe
// Notes:   Ticks are driven by hand, one cycle each, with clock select set except in the stopped-timer test
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic       ref_clk;
    logic       sys_rst;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_rdata;
    logic       tick_en;
    logic       global_ie;
    logic       ack_cmp;
    logic       ack_ovf;
    logic       irq_cmp;
    logic       irq_ovf;
    logic       cnt_top;
    logic       cnt_bot;
    logic       port_out;
    logic       pin_dir;
    logic       oc_pin_o;
    logic       oc_pin_oe;
    int         num_errors;
    int         check_count;
    int         cycles;

    tcu8_top dut
    (
        .REF_CLK              (ref_clk),
        .SYS_RST              (sys_rst),
        .REG_ADDR             (reg_addr),
        .REG_WDATA            (reg_wdata),
        .REG_WR               (reg_wr),
        .REG_RD               (reg_rd),
        .REG_RDATA            (reg_rdata),
        .TICK_EN              (tick_en),
        .GLOBAL_IE            (global_ie),
        .ACK_CMP              (ack_cmp),
        .ACK_OVF              (ack_ovf),
        .IRQ_CMP              (irq_cmp),
        .IRQ_OVF              (irq_ovf),
        .CNT_TOP              (cnt_top),
        .CNT_BOT              (cnt_bot),
        .PORT_OUT             (port_out),
        .OUTPUT_PIN_DIRECTION (pin_dir),
        .OC_PIN_O             (oc_pin_o),
        .OC_PIN_OE            (oc_pin_oe)
    );

    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    task automatic wrap_up();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Hang guard well above the length of the sequence
    always @(posedge ref_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            num_errors = num_errors + 1;
            wrap_up();
        end
    end

    task automatic chk(input string name, input logic [7:0] seen,
                       input logic [7:0] exp);
        check_count = check_count + 1;
        if (seen !== exp)
        begin
            num_errors = num_errors + 1;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp,
                      input string name);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        #1;
        chk(name, reg_rdata, exp);
    endtask

    task automatic tick(input int n);
        repeat (n)
        begin
            @(posedge ref_clk);
            tick_en <= 1'b1;
            @(posedge ref_clk);
            tick_en <= 1'b0;
        end
        #1;
    endtask

    task automatic pulse_ack(input logic ovf);
        @(posedge ref_clk);
        ack_cmp <= ~ovf;
        ack_ovf <= ovf;
        @(posedge ref_clk);
        ack_cmp <= 1'b0;
        ack_ovf <= 1'b0;
        #1;
    endtask

    initial
    begin
        sys_rst = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        tick_en = 1'b0;
        global_ie = 1'b1;
        ack_cmp = 1'b0;
        ack_ovf = 1'b0;
        port_out = 1'b1;
        pin_dir = 1'b1;
        num_errors = 0;
        check_count = 0;
        cycles = 0;
        repeat (20) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        #1;
        for (int i = 0; i < 6; i++)
            rd(i[7:0], 8'h00, "reset read");
        rd(8'h07, 8'h00, "unmapped");
        chk("bottom", {7'h0, cnt_bot}, 8'h01);
        chk("pin port", {7'h0, oc_pin_o}, 8'h01);
        // Stopped timer ignores ticks but the counter stays writable
        wr(tcu8_pkg::ADDR_COUNT, 8'h03);
        tick(3);
        rd(tcu8_pkg::ADDR_COUNT, 8'h03, "stopped count");
        // Normal mode, toggle action, match at 6
        wr(tcu8_pkg::ADDR_CTRL, 8'h14);
        wr(tcu8_pkg::ADDR_CMP, 8'h06);
        wr(tcu8_pkg::ADDR_COUNT, 8'h05);
        tick(2);
        rd(tcu8_pkg::ADDR_COUNT, 8'h07, "count up");
        rd(tcu8_pkg::ADDR_FLAGS, 8'h01, "match flag");
        chk("toggle pin", {7'h0, oc_pin_o}, 8'h01);
        chk("pin oe", {7'h0, oc_pin_oe}, 8'h01);
        wr(tcu8_pkg::ADDR_FLAGS, 8'h00);
        rd(tcu8_pkg::ADDR_FLAGS, 8'h01, "zero write");
        wr(tcu8_pkg::ADDR_IEN, 8'h01);
        chk("irq on", {7'h0, irq_cmp}, 8'h01);
        @(posedge ref_clk);
        global_ie <= 1'b0;
        #1;
        chk("irq masked", {7'h0, irq_cmp}, 8'h00);
        pulse_ack(1'b0);
        rd(tcu8_pkg::ADDR_FLAGS, 8'h00, "ack clears");
        // Counter write while stopped blocks the following match
        wr(tcu8_pkg::ADDR_CTRL, 8'h04);
        wr(tcu8_pkg::ADDR_CMP, 8'h09);
        wr(tcu8_pkg::ADDR_COUNT, 8'h09);
        wr(tcu8_pkg::ADDR_CTRL, 8'h14);
        tick(1);
        rd(tcu8_pkg::ADDR_FLAGS, 8'h00, "blocked");
        chk("no toggle", {7'h0, oc_pin_o}, 8'h01);
        // Action zero: pin follows port, bit untouched by a match
        wr(tcu8_pkg::ADDR_CTRL, 8'h10);
        @(posedge ref_clk);
        port_out <= 1'b0;
        #1;
        chk("port pin", {7'h0, oc_pin_o}, 8'h00);
        wr(tcu8_pkg::ADDR_COUNT, 8'h08);
        tick(2);
        wr(tcu8_pkg::ADDR_CTRL, 8'h14);
        chk("bit kept", {7'h0, oc_pin_o}, 8'h01);
        wr(tcu8_pkg::ADDR_FLAGS, 8'h01);
        rd(tcu8_pkg::ADDR_FLAGS, 8'h00, "one clears");
        // Clear action governs the first match after the write
        wr(tcu8_pkg::ADDR_CTRL, 8'h18);
        wr(tcu8_pkg::ADDR_COUNT, 8'h08);
        tick(2);
        chk("clear pin", {7'h0, oc_pin_o}, 8'h00);
        // Force with set action prepares the bit while the pin is an input
        @(posedge ref_clk);
        pin_dir <= 1'b0;
        wr(tcu8_pkg::ADDR_FLAGS, 8'h01);
        wr(tcu8_pkg::ADDR_CTRL, 8'h9c);
        chk("force pin", {7'h0, oc_pin_o}, 8'h01);
        chk("force oe", {7'h0, oc_pin_oe}, 8'h00);
        @(posedge ref_clk);
        pin_dir <= 1'b1;
        rd(tcu8_pkg::ADDR_FLAGS, 8'h00, "force flag");
        rd(tcu8_pkg::ADDR_COUNT, 8'h0a, "force count");
        rd(tcu8_pkg::ADDR_CTRL, 8'h1c, "ctrl read");
        // CTC mode: top is the compare value, match clears counter
        wr(tcu8_pkg::ADDR_CTRL, 8'h1e);
        chk("mode keep", {7'h0, oc_pin_o}, 8'h01);
        wr(tcu8_pkg::ADDR_CMP, 8'h03);
        rd(tcu8_pkg::ADDR_CMP, 8'h03, "direct cmp");
        wr(tcu8_pkg::ADDR_COUNT, 8'h02);
        tick(1);
        chk("ctc top", {7'h0, cnt_top}, 8'h01);
        tick(1);
        chk("ctc bot", {7'h0, cnt_bot}, 8'h01);
        rd(tcu8_pkg::ADDR_COUNT, 8'h00, "ctc clear");
        rd(tcu8_pkg::ADDR_FLAGS, 8'h01, "ctc flag");
        @(posedge ref_clk);
        pin_dir <= 1'b0;
        #1;
        chk("pin input", {7'h0, oc_pin_oe}, 8'h00);
        @(posedge ref_clk);
        pin_dir <= 1'b1;
        // Normal mode overflow at the maximum
        wr(tcu8_pkg::ADDR_CTRL, 8'h10);
        wr(tcu8_pkg::ADDR_FLAGS, 8'h03);
        wr(tcu8_pkg::ADDR_COUNT, 8'hff);
        chk("max top", {7'h0, cnt_top}, 8'h01);
        wr(tcu8_pkg::ADDR_IEN, 8'h02);
        @(posedge ref_clk);
        global_ie <= 1'b1;
        tick(1);
        chk("wrap bot", {7'h0, cnt_bot}, 8'h01);
        rd(tcu8_pkg::ADDR_FLAGS, 8'h02, "overflow");
        chk("irq ovf", {7'h0, irq_ovf}, 8'h01);
        pulse_ack(1'b1);
        rd(tcu8_pkg::ADDR_FLAGS, 8'h00, "ovf ack");
        // Fast PWM: buffered compare loads only at wrap
        wr(tcu8_pkg::ADDR_CTRL, 8'h1b);
        wr(tcu8_pkg::ADDR_CMP, 8'h05);
        rd(tcu8_pkg::ADDR_CMP, 8'h05, "buffer read");
        wr(tcu8_pkg::ADDR_COUNT, 8'h02);
        tick(2);
        rd(tcu8_pkg::ADDR_FLAGS, 8'h01, "old active");
        chk("pwm clear", {7'h0, oc_pin_o}, 8'h00);
        wr(tcu8_pkg::ADDR_FLAGS, 8'h01);
        wr(tcu8_pkg::ADDR_COUNT, 8'hff);
        // Old compare value 3 would match within these six ticks
        tick(6);
        rd(tcu8_pkg::ADDR_FLAGS, 8'h02, "no early match");
        chk("pwm wrap set", {7'h0, oc_pin_o}, 8'h01);
        tick(1);
        rd(tcu8_pkg::ADDR_FLAGS, 8'h03, "new active");
        chk("pwm match", {7'h0, oc_pin_o}, 8'h00);
        // Phase PWM turns round at the maximum and counts down
        wr(tcu8_pkg::ADDR_CTRL, 8'h19);
        wr(tcu8_pkg::ADDR_COUNT, 8'hff);
        tick(2);
        rd(tcu8_pkg::ADDR_COUNT, 8'hfd, "count down");
        wr(tcu8_pkg::ADDR_COUNT, 8'h06);
        tick(2);
        chk("phase down set", {7'h0, oc_pin_o}, 8'h01);
        // Reset in mid-run clears the output bit
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        #1;
        wr(tcu8_pkg::ADDR_CTRL, 8'h14);
        chk("reset bit", {7'h0, oc_pin_o}, 8'h00);
        wrap_up();
    end
endmodule
